// ==== rtl/watchdog_trap.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "guard_params.svh"

module watchdog_trap #(
  parameter int FAST_QUARTER_LOG2 = `FAST_QUARTER_LOG2,
  parameter int SLOW_QUARTER_LOG2 = `SLOW_QUARTER_LOG2
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [9:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        LOW_SPEED_MODE_ONE,
  input  wire logic        DIVIDER_STAGE_SELECT,
  input  wire logic        SLOW_CLOCK_TICK,
  input  wire logic        FETCH_VALID,
  input  wire logic [15:0] FETCH_ADDR,
  output logic             OVERFLOW_INTERRUPT,
  output logic             FETCH_TRAP_INTERRUPT,
  output logic             RESET_REQUEST,
  output logic             OSC_RESTART
);
  import guard_pkg::*;

  localparam logic [9:0] CTRL_ADDR = {`CONTROL_REG_INDEX, 2'b00};
  localparam logic [9:0] CODE_ADDR = {`CODE_REG_INDEX, 2'b00};
  localparam logic [9:0] STAT_ADDR = {`STATUS_REG_INDEX, 2'b00};
  localparam logic [4:0] HOLD_LAST = 5'(`RESET_CYCLES - 1);

  // ------------------------------------------------------------
  // apb slave: one wait state, answer registered
  // ------------------------------------------------------------
  logic        access;
  logic        wr_ctrl;
  logic        wr_code;
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;
  logic        mapped;

  // a write lands only at the edge where pready is seen high
  assign access  = PSEL && PENABLE && PREADY;
  assign wr_ctrl = access && PWRITE && (PADDR == CTRL_ADDR);
  assign wr_code = access && PWRITE && (PADDR == CODE_ADDR);

  // ------------------------------------------------------------
  // control state
  // ------------------------------------------------------------
  logic      enable_bit;
  logic      running;
  logic      ovf_sel;
  time_sel_t time_sel;
  logic      trap_act;
  logic      ram_sel;
  logic      ram_armed;
  logic      next_enable_bit;
  logic      next_running;
  logic      next_ovf_sel;
  time_sel_t next_time_sel;
  logic      next_trap_act;
  logic      next_ram_sel;
  logic      next_ram_armed;
  logic      code_clear;
  logic      code_disable;
  logic      code_arm;

  assign code_clear   = wr_code && (PWDATA[7:0] == `CLEAR_CODE);
  assign code_disable = wr_code && (PWDATA[7:0] == `DISABLE_CODE);
  assign code_arm     = wr_code && (PWDATA[7:0] == `TRAP_ARM_CODE);

  always_comb begin
    next_enable_bit = enable_bit;
    next_running    = running;
    next_ovf_sel    = ovf_sel;
    next_time_sel   = time_sel;
    next_trap_act   = trap_act;
    next_ram_sel    = ram_sel;
    next_ram_armed  = ram_armed;
    if (wr_ctrl) begin
      next_enable_bit = PWDATA[`ENABLE_BIT];
      next_time_sel   = PWDATA[`TIME_SEL_MSB:`TIME_SEL_LSB];
      next_trap_act   = PWDATA[`TRAP_ACT_BIT];
      next_ram_sel    = PWDATA[`RAM_SEL_BIT];
      next_ovf_sel    = ovf_sel && PWDATA[`OVF_SEL_BIT];
      if (PWDATA[`ENABLE_BIT]) begin
        next_running = 1'b1;
      end
    end
    // only stops when the enable bit already reads zero
    if (code_disable && !enable_bit) begin
      next_running = 1'b0;
    end
    // new ram select waits for the arm code
    if (code_arm) begin
      next_ram_armed = ram_sel;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      enable_bit <= 1'((`CONTROL_RESET >> `ENABLE_BIT) & 8'h01);
      running    <= 1'b1;
      ovf_sel    <= 1'b1;
      time_sel   <= 2'b00;
      trap_act   <= 1'b1;
      ram_sel    <= 1'b1;
      ram_armed  <= 1'b1;
    end else begin
      enable_bit <= next_enable_bit;
      running    <= next_running;
      ovf_sel    <= next_ovf_sel;
      time_sel   <= next_time_sel;
      trap_act   <= next_trap_act;
      ram_sel    <= next_ram_sel;
      ram_armed  <= next_ram_armed;
    end
  end

  // ------------------------------------------------------------
  // divider and two-stage binary counter
  // ------------------------------------------------------------
  logic [23:0] div;
  logic [23:0] next_div;
  logic [1:0]  bin_cnt;
  logic [1:0]  next_bin_cnt;
  logic        src_tick;
  logic        slow_src;
  logic [4:0]  tap_log2;
  logic [23:0] tap_mask;
  logic        quarter_tick;
  logic        ovf_event;

  // quarter of the period: the counter overflows on the fourth tick
  always_comb begin
    slow_src = LOW_SPEED_MODE_ONE || DIVIDER_STAGE_SELECT;
    src_tick = slow_src ? SLOW_CLOCK_TICK : 1'b1;
    if (slow_src) begin
      tap_log2 = 5'(SLOW_QUARTER_LOG2) - {2'b00, time_sel, 1'b0};
    end else begin
      tap_log2 = 5'(FAST_QUARTER_LOG2) - {2'b00, time_sel, 1'b0};
    end
    tap_mask     = ~(24'hffffff << tap_log2);
    quarter_tick = src_tick && (&(div | ~tap_mask));
    ovf_event    = running && quarter_tick && (bin_cnt == 2'h3);
    next_div     = src_tick ? div + 24'h000001 : div;
    // clear code spares the divider, so the first overflow may come early
    if (!running || code_clear) begin
      next_bin_cnt = 2'h0;
    end else if (quarter_tick) begin
      next_bin_cnt = bin_cnt + 2'h1;
    end else begin
      next_bin_cnt = bin_cnt;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      div     <= 24'h000000;
      bin_cnt <= 2'h0;
    end else begin
      div     <= next_div;
      bin_cnt <= next_bin_cnt;
    end
  end

  // ------------------------------------------------------------
  // address trap
  // ------------------------------------------------------------
  logic trap_hit;

  fetch_trap_check u_trap (
    .fetch_valid (FETCH_VALID),
    .fetch_addr  (FETCH_ADDR),
    .ram_armed   (ram_armed),
    .trap_hit    (trap_hit)
  );

  // ------------------------------------------------------------
  // event outputs and reset hold
  // ------------------------------------------------------------
  reset_state_t rst_state;
  reset_state_t next_rst_state;
  logic [4:0]   hold_cnt;
  logic [4:0]   next_hold_cnt;
  logic         reset_event;
  logic         next_ovf_irq;
  logic         next_trap_irq;
  logic         next_osc_restart;

  // no master-flag gate: both interrupts are non-maskable, and every event
  // pulses again even while an earlier one is in service, so the cpu nests
  always_comb begin
    next_ovf_irq  = ovf_event && !ovf_sel;
    next_trap_irq = trap_hit && !trap_act;
    reset_event   = (ovf_event && ovf_sel) || (trap_hit && trap_act);
    next_rst_state   = rst_state;
    next_hold_cnt    = hold_cnt;
    next_osc_restart = 1'b0;
    case (rst_state)
      RST_IDLE: begin
        if (reset_event) begin
          next_rst_state   = RST_HOLD;
          next_hold_cnt    = HOLD_LAST;
          next_osc_restart = LOW_SPEED_MODE_ONE;
        end
      end
      RST_HOLD: begin
        // further events inside the hold merge into it
        if (hold_cnt == 5'h00) begin
          next_rst_state = RST_IDLE;
        end else begin
          next_hold_cnt = hold_cnt - 5'h01;
        end
      end
      default: begin
        next_rst_state = RST_IDLE;
        next_hold_cnt  = 5'h00;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rst_state            <= RST_IDLE;
      hold_cnt             <= 5'h00;
      OVERFLOW_INTERRUPT   <= 1'b0;
      FETCH_TRAP_INTERRUPT <= 1'b0;
      RESET_REQUEST        <= 1'b0;
      OSC_RESTART          <= 1'b0;
    end else begin
      rst_state            <= next_rst_state;
      hold_cnt             <= next_hold_cnt;
      OVERFLOW_INTERRUPT   <= next_ovf_irq;
      FETCH_TRAP_INTERRUPT <= next_trap_irq;
      RESET_REQUEST        <= (next_rst_state == RST_HOLD);
      OSC_RESTART          <= next_osc_restart;
    end
  end

  // ------------------------------------------------------------
  // apb answer
  // ------------------------------------------------------------
  // control and code registers are write-only and read back as zero
  always_comb begin
    mapped       = (PADDR == CTRL_ADDR) || (PADDR == CODE_ADDR) || (PADDR == STAT_ADDR);
    next_pready  = PSEL && PENABLE && !PREADY;
    next_pslverr = next_pready && !mapped;
    next_prdata  = 32'h00000000;
    if (next_pready && !PWRITE && (PADDR == STAT_ADDR)) begin
      next_prdata = {21'h000000, RESET_REQUEST, bin_cnt, ram_sel, ram_armed,
                     trap_act, enable_bit, time_sel, ovf_sel, running};
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
      PRDATA  <= next_prdata;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  ovf_sel_sticky_a: assert property (!ovf_sel |=> !ovf_sel)
    else $error("overflow select returned to one");

  idle_counter_clear_a: assert property (!running |=> bin_cnt == 2'h0)
    else $error("binary counter moved while disabled");

  ovf_irq_path_a: assert property (ovf_event && !ovf_sel |=> OVERFLOW_INTERRUPT)
    else $error("overflow did not raise interrupt");

  reset_hold_len_a: assert property ($rose(RESET_REQUEST) |-> ##23 RESET_REQUEST ##1 !RESET_REQUEST)
    else $error("reset request length not 24 cycles");

  trap_irq_path_a: assert property (trap_hit && !trap_act |=> FETCH_TRAP_INTERRUPT)
    else $error("trap did not raise interrupt");

  sfr_fetch_trap_a: assert property (FETCH_VALID && FETCH_ADDR <= 16'h003f |-> trap_hit)
    else $error("sfr fetch did not trap");

  ram_arm_code_a: assert property ($changed(ram_armed) |-> $past(code_arm))
    else $error("ram select armed without code");

  disable_ignored_a: assert property (code_disable && enable_bit && running |=> running)
    else $error("disable code honoured while enabled");

  slow_osc_restart_a: assert property ($rose(RESET_REQUEST) |-> OSC_RESTART == $past(LOW_SPEED_MODE_ONE))
    else $error("oscillator restart mismatch");

endmodule // watchdog_trap

`default_nettype wire

// ==== rtl/guard_params.svh ====
`ifndef GUARD_PARAMS_SVH
`define GUARD_PARAMS_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define CONTROL_REG_INDEX   8'h34
`define CODE_REG_INDEX      8'h35
`define STATUS_REG_INDEX    8'h38

// ------------------------------------------------------------
// control register fields and reset value
// ------------------------------------------------------------
`define OVF_SEL_BIT         0
`define TIME_SEL_LSB        1
`define TIME_SEL_MSB        2
`define ENABLE_BIT          3
`define TRAP_ACT_BIT        4
`define RAM_SEL_BIT         5
`define CONTROL_RESET       8'h39

// ------------------------------------------------------------
// code register values
// ------------------------------------------------------------
`define CLEAR_CODE          8'h4e
`define DISABLE_CODE        8'hb1
`define TRAP_ARM_CODE       8'hd2

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS       20
`define RESET_FC_PERIODS    24
`define RESET_TIME_NS       (`RESET_FC_PERIODS * `CLK_PERIOD_NS)
`define RESET_CYCLES        (`RESET_TIME_NS / `CLK_PERIOD_NS)
`define FAST_QUARTER_LOG2   23
`define SLOW_QUARTER_LOG2   15

`endif

// ==== rtl/guard_pkg.sv ====
package guard_pkg;

  typedef enum logic [1:0] {
    RST_IDLE = 2'b01,
    RST_HOLD = 2'b10
  } reset_state_t;

  typedef logic [1:0] time_sel_t;

endpackage

// ==== rtl/fetch_trap_check.sv ====
`timescale 1ns/1ps
`default_nettype none

module fetch_trap_check #(
  parameter logic [15:0] RAM_LO = 16'h0040,
  parameter logic [15:0] RAM_HI = 16'h083f,
  parameter logic [15:0] SFR_LO = 16'h0000,
  parameter logic [15:0] SFR_HI = 16'h003f,
  parameter logic [15:0] DBR_LO = 16'h0f80,
  parameter logic [15:0] DBR_HI = 16'h0fff
) (
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        ram_armed,
  output logic             trap_hit
);

  logic in_ram;
  logic in_sfr;
  logic in_dbr;

  // same-cycle compare against the three regions
  always_comb begin
    in_ram   = (fetch_addr >= RAM_LO) && (fetch_addr <= RAM_HI);
    in_sfr   = (fetch_addr >= SFR_LO) && (fetch_addr <= SFR_HI);
    in_dbr   = (fetch_addr >= DBR_LO) && (fetch_addr <= DBR_HI);
    // sfr and debug regions trap whatever the ram select says
    trap_hit = fetch_valid && ((in_ram && ram_armed) || in_sfr || in_dbr);
  end

endmodule // fetch_trap_check

`default_nettype wire

// ==== verification/cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "guard_params.svh"
// ------------------------------------------------------------
// core side: apb master and opcode fetch strobe
// ------------------------------------------------------------
module cpu_model (
  input  wire logic        clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [9:0]       paddr,
  output logic [31:0]      pwdata,
  output logic             fetch_valid,
  output logic [15:0]      fetch_addr
);
  localparam logic [9:0] A_CTL  = {`CONTROL_REG_INDEX, 2'b00};
  localparam logic [9:0] A_CODE = {`CODE_REG_INDEX, 2'b00};
  logic stack_ready;
  initial begin
    {psel, penable, pwrite, fetch_valid, stack_ready} = '0;
    paddr = '0;
    pwdata = '0;
    fetch_addr = '0;
  end
  // released lines show the inverse so stale values never pass
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic fetch(input logic [15:0] a);
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    @(posedge clk);
    fetch_valid <= 1'b0;
    fetch_addr <= ~a;
  endtask
  // stack pointer set before any nmi source is chosen
  task automatic set_irq_mode(input logic [31:0] ctl);
    stack_ready = 1'b1;
    wr(A_CTL, ctl);
  endtask
  // master flag assumed cleared by the core first
  task automatic stop_guard(input logic [31:0] ctl);
    wr(A_CODE, {24'h0, `CLEAR_CODE});
    wr(A_CTL, ctl);
    wr(A_CODE, {24'h0, `DISABLE_CODE});
  endtask
endmodule // cpu_model
`default_nettype wire

// ==== verification/watchdog_with_address_trap_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "guard_params.svh"
module watchdog_with_address_trap_tb_top;
  localparam logic [9:0] A_CTL = {`CONTROL_REG_INDEX, 2'b00};
  localparam logic [9:0] A_CODE = {`CODE_REG_INDEX, 2'b00};
  localparam logic [9:0] A_STS = {`STATUS_REG_INDEX, 2'b00};
  logic clk, rst, slow_on, stage_sel, slow_tick, psel, penable, pwrite, pready, pslverr;
  logic fv, ovf, trap, rreq, osc;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic [15:0] fa;
  logic        e;
  int          n_errors, samples_checked, n;
  watchdog_trap #(.FAST_QUARTER_LOG2(8), .SLOW_QUARTER_LOG2(8)) uut (
    .REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LOW_SPEED_MODE_ONE(slow_on), .DIVIDER_STAGE_SELECT(stage_sel),
    .SLOW_CLOCK_TICK(slow_tick), .FETCH_VALID(fv), .FETCH_ADDR(fa),
    .OVERFLOW_INTERRUPT(ovf), .FETCH_TRAP_INTERRUPT(trap),
    .RESET_REQUEST(rreq), .OSC_RESTART(osc));
  cpu_model cpu (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .fetch_valid(fv), .fetch_addr(fa));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // slow ticks every other cycle whenever a slow source is selected
  always @(posedge clk) slow_tick <= (slow_on | stage_sel) & ~slow_tick;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic outsig(input int s);
    case (s)
      0: return ovf;
      1: return trap;
      default: return rreq;
    endcase
  endfunction
  task automatic wait_hi(input int s, input int lim, output int c);
    c = 0;
    while (outsig(s) !== 1'b1 && c < lim) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask
  task automatic len_hi(input int s, output int c);
    c = 0;
    while (outsig(s) === 1'b1 && c < 100) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask
  task automatic status(input logic [7:0] exp);
    cpu.xfer(1'b0, A_STS, 32'h0, d, e);
    chk(d & 32'hff, {24'h0, exp});
  endtask
  task automatic trap_case(input logic [15:0] a, input logic exp);
    cpu.fetch(a);
    #1;
    chk({31'h0, trap}, {31'h0, exp});
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({28'h0, ovf, trap, rreq, osc}, 32'h0);
    @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #(20 * 20000);
    n_errors++;
    summarize();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {rst, slow_on, stage_sel} = 3'b100;
    n_errors = 0;
    samples_checked = 0;
    do_reset();
    status(8'hf3);
    cpu.xfer(1'b1, 10'h3fc, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    $display("test reset_state done");
    cpu.fetch(16'h0010);
    #1;
    chk({31'h0, rreq}, 32'h1);
    len_hi(2, n);
    chk(n, 24);
    $display("test trap_reset done");
    cpu.set_irq_mode(32'h2e);
    wait_hi(0, 3000, n);
    @(posedge clk);
    #1;
    wait_hi(0, 100, n);
    chk(n + 1, 16);
    cpu.wr(A_CTL, 32'h2f);
    status(8'hdd);
    wait_hi(0, 100, n);
    chk({31'h0, n < 100}, 32'h1);
    chk({31'h0, rreq}, 32'h0);
    $display("test overflow_irq done");
    trap_case(16'h0100, 1'b1);
    cpu.wr(A_CTL, 32'h0e);
    trap_case(16'h0100, 1'b1);
    cpu.wr(A_CODE, {24'h0, `TRAP_ARM_CODE});
    trap_case(16'h0100, 1'b0);
    trap_case(16'h0f90, 1'b1);
    trap_case(16'h0020, 1'b1);
    chk({31'h0, rreq}, 32'h0);
    $display("test trap_irq done");
    cpu.wr(A_CODE, {24'h0, `DISABLE_CODE});
    status(8'h1d);
    cpu.stop_guard(32'h06);
    cpu.xfer(1'b0, A_STS, 32'h0, d, e);
    chk(d, 32'h0c);
    wait_hi(0, 200, n);
    chk(n, 200);
    cpu.wr(A_CTL, 32'h0e);
    wait_hi(0, 200, n);
    chk({31'h0, n <= 20}, 32'h1);
    $display("test disable done");
    @(posedge clk);
    slow_on <= 1'b1;
    do_reset();
    status(8'hf3);
    cpu.wr(A_CTL, 32'h3f);
    wait_hi(2, 300, n);
    chk({31'h0, osc}, 32'h1);
    len_hi(2, n);
    chk(n, 24);
    $display("test overflow_reset done");
    @(posedge clk);
    slow_on <= 1'b0;
    stage_sel <= 1'b1;
    do_reset();
    cpu.wr(A_CTL, 32'h3e);
    wait_hi(0, 300, n);
    @(posedge clk);
    #1;
    wait_hi(0, 100, n);
    chk(n + 1, 32);
    cpu.fetch(16'h0020);
    #1;
    chk({30'h0, rreq, osc}, 32'h2);
    $display("test stage_select done");
    summarize();
  end
endmodule // watchdog_with_address_trap_tb_top
`default_nettype wire
